// ==== shared/chs_pkg.sv ====
// shared constants and types for the coprocessor handshake sequencer
package chs_pkg;

  localparam int unsigned CHS_DW       = 32;
  localparam int unsigned CHS_CW       = 4;
  // address offsets from the instruction address and the transfer step, then reset, count and level values
  localparam logic [31:0] CHS_PC_REQ   = 32'h0000_0008;
  localparam logic [31:0] CHS_PC_NEXT  = 32'h0000_000C;
  localparam logic [31:0] CHS_STEP     = 32'h0000_0004;
  localparam logic [31:0] CHS_ADDR_RST = 32'h0000_0000;
  localparam logic [31:0] CHS_WORD_RST = 32'h0000_0000;
  localparam logic [3:0]  CHS_CNT_ONE  = 4'h1;
  localparam logic [1:0]  CHS_LVL_ZERO = 2'h0;
  localparam logic [1:0]  CHS_LVL_FULL = 2'h2;

  // operation carried beside the coprocessor request
  typedef enum logic [1:0]
  {
    CHS_OP_DATA  = 2'h0,
    CHS_OP_LOAD  = 2'h1,
    CHS_OP_STORE = 2'h2
  } chs_op_t;

  // processor end sequencer states
  typedef enum logic [5:0]
  {
    CHS_C_IDLE  = 6'h01,
    CHS_C_ISSUE = 6'h02,
    CHS_C_WAIT  = 6'h04,
    CHS_C_XFER  = 6'h08,
    CHS_C_FETCH = 6'h10,
    CHS_C_TRAP  = 6'h20
  } chs_cpu_st_t;

  // coprocessor end states
  typedef enum logic [1:0]
  {
    CHS_P_IDLE = 2'h1,
    CHS_P_XFER = 2'h2
  } chs_cop_st_t;

endpackage

// ==== shared/chs_link_if.sv ====
// link between the processor end and the coprocessor end
`timescale 1ns/100ps
interface chs_link_if;
  import chs_pkg::*;

  logic [31:0] addr;
  logic        mem_request_n;
  logic        burst_follow;
  logic        opcode_fetch_n;
  logic        coproc_instr_n;
  logic        write_not_read;
  logic        byte_not_word;
  chs_op_t     op;
  logic        coproc_absent;
  logic        coproc_busy;
  logic [31:0] mem_rdata;
  logic [31:0] coproc_word;
  logic        coproc_word_oe;

  // processor side
  modport cpu
  (
    output addr, mem_request_n, burst_follow, opcode_fetch_n,
    output coproc_instr_n, write_not_read, byte_not_word, op,
    input  coproc_absent, coproc_busy
  );

  // coprocessor side; mem_rdata comes from the memory model
  modport cop
  (
    input  addr, mem_request_n, burst_follow, opcode_fetch_n,
    input  coproc_instr_n, write_not_read, byte_not_word, op,
    input  mem_rdata,
    output coproc_absent, coproc_busy, coproc_word, coproc_word_oe
  );
endinterface

// ==== rtl/chs_pair_buf.sv ====
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/100ps
module chs_pair_buf
  import chs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [CHS_DW-1:0] in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [CHS_DW-1:0]      out_data,
  output logic [1:0]             level
);

  typedef struct packed {
    logic [1:0][CHS_DW-1:0] mem;
    logic                   wp;
    logic                   rp;
    logic [1:0]             cnt;
  } chs_buf_t;

  chs_buf_t s_q;
  chs_buf_t s_d;
  logic     push;
  logic     pop;

  ////////////////////////////////////////////////////////////////////////
  // handshakes straight from the fill count
  assign in_ready  = (s_q.cnt != CHS_LVL_FULL);
  assign out_valid = (s_q.cnt != CHS_LVL_ZERO);
  assign out_data  = s_q.mem[s_q.rp];
  assign level     = s_q.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update; push and pop may share a cycle
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp          = ~s_q.wp;
    end
    if (pop)
    begin
      s_d.rp = ~s_q.rp;
    end
    if (push && !pop)
    begin
      s_d.cnt = s_q.cnt + 2'h1;
    end
    else if (pop && !push)
    begin
      s_d.cnt = s_q.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// ==== rtl/chs_cop_end.sv ====
// coprocessor end: answers requests and moves transfer words
`timescale 1ns/100ps
module chs_cop_end
  import chs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  chs_link_if.cop                link,
  input  wire logic [2:0]        supported,
  input  wire logic              can_commit,
  input  wire logic [CHS_CW-1:0] word_count,
  output logic                   dop_go,
  output logic                   ld_valid,
  input  wire logic              ld_ready,
  output logic [CHS_DW-1:0]      ld_data,
  input  wire logic [CHS_DW-1:0] st_data,
  output logic                   st_next
);

  typedef struct packed {
    chs_cop_st_t       st;
    chs_op_t           op;
    logic [CHS_CW-1:0] rem;
    logic [CHS_DW-1:0] word;
  } chs_cop_t;

  chs_cop_t   s_q;
  chs_cop_t   s_d;
  logic       req;
  logic       can;
  logic       rdy;
  logic       commit;
  logic       xfer;
  logic       last;
  logic       push;
  logic       in_ready;
  logic [1:0] level;

  ////////////////////////////////////////////////////////////////////////
  assign req  = !link.coproc_instr_n && (s_q.st == CHS_P_IDLE);
  assign can  = supported[link.op];
  assign xfer = (s_q.st == CHS_P_XFER);
  // loads wait for an empty buffer, since the processor cannot be stalled
  // commit when room
  assign rdy    = can_commit && ((link.op != CHS_OP_LOAD) || (in_ready && level == CHS_LVL_ZERO));
  assign commit = req && can && rdy;
  // the buffer holds two words, so a slow reader shortens the burst
  // count and last flag
  // a waiting word cuts the burst when the reader leaves it standing or the buffer is full
  assign last = (s_q.rem <= CHS_CNT_ONE) ||
                ((s_q.op == CHS_OP_LOAD) && (level != CHS_LVL_ZERO) &&
                 !(ld_ready && (level != CHS_LVL_FULL)));

  // response pins; idle and refusals leave both high
  always_comb
  begin
    link.coproc_absent = 1'b1;
    link.coproc_busy   = 1'b1;
    if (req)
    begin
      link.coproc_absent = ~can;
      link.coproc_busy   = ~commit;
    end
    else if (xfer)
    begin
      link.coproc_absent = last;
      link.coproc_busy   = last;
    end
  end

  assign push                = xfer && (s_q.op == CHS_OP_LOAD);
  assign link.coproc_word_oe = xfer && (s_q.op == CHS_OP_STORE);
  assign link.coproc_word    = s_q.word;
  assign dop_go              = commit && (link.op == CHS_OP_DATA);
  assign st_next             = (commit && link.op == CHS_OP_STORE) || (link.coproc_word_oe && !last);

  ////////////////////////////////////////////////////////////////////////
  // sequencing; a zero word count still moves one word
  always_comb
  begin
    s_d = s_q;
    if (st_next)
    begin
      s_d.word = st_data;
    end
    if (commit && link.op != CHS_OP_DATA)
    begin
      s_d.st  = CHS_P_XFER;
      s_d.op  = link.op;
      s_d.rem = word_count;
    end
    else if (xfer)
    begin
      s_d.rem = s_q.rem - CHS_CNT_ONE;
      if (last)
      begin
        s_d.st = CHS_P_IDLE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{st: CHS_P_IDLE, op: CHS_OP_DATA, rem: '0, word: CHS_WORD_RST};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // incoming words wait here for the user side
  chs_pair_buf u_buf
  (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (link.mem_rdata),
    .out_valid (ld_valid),
    .out_ready (ld_ready),
    .out_data  (ld_data),
    .level     (level)
  );

endmodule

// ==== rtl/chs_cpu_end.sv ====
// processor end: sequences coprocessor data operations and transfers
// Notes on behaviour
// - first cycle: request low, fetch low, pc+8
// - coprocessor commits in the cycle it drops busy
// - never able: absent and busy high
// - not ready: absent low, busy high
// - stall while busy high, go when low
// - wait cycles pc+8, final cycle request low
// - ready at once: single cycle, then pc+12
// - load commit only when ready for words
// - sequential addresses, one word each cycle
// - coprocessor sets count, flags last high
// - address in first cycle, write-back later
// - load transfer: request low, read, incrementing
// - sequential except last, then fetch pc+12
// - store transfer same, write_not_read high
// - coprocessor drives store word on bus
// - byte_not_word always high: word accesses
// - unable coprocessor never drives pins low
`timescale 1ns/100ps
module chs_cpu_end
  import chs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  chs_link_if.cpu                link,
  input  wire logic              start,
  input  wire chs_op_t           op_in,
  input  wire logic [CHS_DW-1:0] pc_in,
  input  wire logic [CHS_DW-1:0] base_in,
  input  wire logic [CHS_DW-1:0] offset_in,
  output logic                   ready,
  output logic                   done,
  output logic                   undef_trap,
  output logic [CHS_DW-1:0]      wb_base,
  output logic [1:0]             resp_seen
);

  typedef struct packed {
    chs_cpu_st_t       st;
    chs_op_t           op;
    logic [CHS_DW-1:0] pc;
    logic [CHS_DW-1:0] xa;
    logic [CHS_DW-1:0] off;
    logic [CHS_DW-1:0] addr;
    logic [CHS_DW-1:0] wb;
    logic [1:0]        resp;
  } chs_cpu_t;

  chs_cpu_t          s_q;
  chs_cpu_t          s_d;
  logic              asking;
  logic              refuse;
  logic              last;
  logic [CHS_DW-1:0] xa_now;

  ////////////////////////////////////////////////////////////////////////
  // decode of the live response
  assign asking = (s_q.st == CHS_C_ISSUE) || (s_q.st == CHS_C_WAIT);
  assign refuse = link.coproc_absent && link.coproc_busy;
  assign last   = link.coproc_absent && link.coproc_busy;
  assign xa_now = (s_q.st == CHS_C_ISSUE) ? (s_q.xa + s_q.off) : s_q.xa;

  // status towards the user
  assign ready      = (s_q.st == CHS_C_IDLE);
  assign done       = (s_q.st == CHS_C_FETCH);
  assign undef_trap = (s_q.st == CHS_C_TRAP);
  assign wb_base    = s_q.wb;
  assign resp_seen  = s_q.resp;
  assign link.addr  = s_q.addr;
  assign link.op    = s_q.op;

  ////////////////////////////////////////////////////////////////////////
  // link strobes; request follows live busy so a ready answer
  // finishes in the issuing cycle itself
  always_comb
  begin
    link.byte_not_word  = 1'b1;
    link.coproc_instr_n = 1'b1;
    link.opcode_fetch_n = 1'b1;
    link.mem_request_n  = 1'b1;
    link.burst_follow   = 1'b0;
    link.write_not_read = 1'b0;
    case (s_q.st)
      CHS_C_ISSUE:
      begin
        link.coproc_instr_n = 1'b0;
        link.opcode_fetch_n = 1'b0;
        link.mem_request_n  = link.coproc_busy;
      end
      CHS_C_WAIT:
      begin
        link.coproc_instr_n = 1'b0;
        link.mem_request_n  = link.coproc_busy;
      end
      CHS_C_XFER:
      begin
        link.mem_request_n  = 1'b0;
        link.burst_follow   = ~last;
        link.write_not_read = (s_q.op == CHS_OP_STORE);
      end
      CHS_C_FETCH:
      begin
        link.mem_request_n  = 1'b0;
        link.opcode_fetch_n = 1'b0;
      end
      CHS_C_TRAP:
      begin
        link.mem_request_n  = 1'b0;
        link.opcode_fetch_n = 1'b0;
      end
      default:
      begin
        link.mem_request_n  = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer; the state register is the sampling point of the response
  always_comb
  begin
    s_d = s_q;
    s_d.resp = {link.coproc_absent, link.coproc_busy};
    case (s_q.st)
      CHS_C_IDLE:
      begin
        if (start)
        begin
          s_d.st   = CHS_C_ISSUE;
          s_d.op   = op_in;
          s_d.pc   = pc_in;
          s_d.xa   = base_in;
          s_d.off  = offset_in;
          s_d.addr = pc_in + CHS_PC_REQ;
        end
      end
      CHS_C_ISSUE, CHS_C_WAIT:
      begin
        s_d.xa = xa_now;
        if (refuse)
        begin
          // undefined: hand over to the trap cycle
          s_d.st = CHS_C_TRAP;
        end
        else if (!link.coproc_busy)
        begin
          if (s_q.op == CHS_OP_DATA)
          begin
            s_d.st   = CHS_C_FETCH;
            s_d.addr = s_q.pc + CHS_PC_NEXT;
          end
          else
          begin
            s_d.st   = CHS_C_XFER;
            s_d.addr = xa_now;
          end
        end
        else
        begin
          s_d.st = CHS_C_WAIT;
        end
      end
      CHS_C_XFER:
      begin
        s_d.wb = s_q.addr + CHS_STEP;
        if (last)
        begin
          s_d.st   = CHS_C_FETCH;
          s_d.addr = s_q.pc + CHS_PC_NEXT;
        end
        else
        begin
          s_d.addr = s_q.addr + CHS_STEP;
        end
      end
      CHS_C_FETCH:
      begin
        s_d.st = CHS_C_IDLE;
      end
      CHS_C_TRAP:
      begin
        s_d.st = CHS_C_IDLE;
      end
      default:
      begin
        s_d.st = CHS_C_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '{st: CHS_C_IDLE, op: CHS_OP_DATA, pc: CHS_ADDR_RST, xa: CHS_ADDR_RST,
               off: CHS_ADDR_RST, addr: CHS_ADDR_RST, wb: CHS_ADDR_RST, resp: 2'h3};
    end
    else
    begin
      s_q <= s_d;
    end
  end

endmodule

// ==== bench/chs_link_monitor.sv ====
// link checker between processor end and coprocessor end
`timescale 1ns/100ps
module chs_link_monitor
  import chs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [31:0] addr,
  input wire logic        mem_request_n,
  input wire logic        burst_follow,
  input wire logic        opcode_fetch_n,
  input wire logic        coproc_instr_n,
  input wire logic        write_not_read,
  input wire logic        byte_not_word,
  input wire chs_op_t     op,
  input wire logic        coproc_absent,
  input wire logic        coproc_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // transfer cycle: no request, no fetch, memory busy
  wire logic xfer = coproc_instr_n & opcode_fetch_n & ~mem_request_n;
  wire logic last = coproc_absent & coproc_busy;
  ////////////////////////////////////////
  a_word_only: assert property (byte_not_word)
    else $error("byte access seen");
  a_issue_fetch: assert property ($fell(coproc_instr_n) |-> !opcode_fetch_n)
    else $error("issue without fetch");
  a_wait_stall: assert property (!coproc_instr_n && !coproc_absent && coproc_busy
    |-> mem_request_n ##1 !coproc_instr_n && opcode_fetch_n && $stable(addr))
    else $error("wait cycle wrong");
  a_commit_go: assert property (!coproc_instr_n && !coproc_busy |-> !mem_request_n)
    else $error("commit without request");
  a_data_next: assert property (!coproc_instr_n && !coproc_busy && op == CHS_OP_DATA
    |=> !opcode_fetch_n && !mem_request_n && addr == $past(addr) + CHS_STEP)
    else $error("data op not followed by fetch");
  a_commit_xfer: assert property (!coproc_instr_n && !coproc_busy && op != CHS_OP_DATA |=> xfer)
    else $error("transfer not started");
  a_xfer_dir: assert property (xfer |-> write_not_read == (op == CHS_OP_STORE))
    else $error("transfer direction wrong");
  a_burst_mark: assert property (xfer |-> burst_follow == !last)
    else $error("sequential mark wrong");
  a_addr_step: assert property (xfer && !last |=> xfer && addr == $past(addr) + CHS_STEP)
    else $error("transfer address not stepped");
  a_last_fetch: assert property (xfer && last |=> coproc_instr_n && !opcode_fetch_n)
    else $error("no fetch after last word");
  a_trap_path: assert property (!coproc_instr_n && last |=> coproc_instr_n && $stable(addr))
    else $error("refused request not trapped");
endmodule

// ==== bench/testbench.sv ====
// self-checking bench joining both ends across the link
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((e) !== (g)) begin n_mismatch++; \
  $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
  import chs_pkg::*;
  localparam logic [31:0] PC   = 32'h0000_1000;
  localparam logic [31:0] BASE = 32'h0000_2000;
  localparam logic [31:0] OFF  = 32'h0000_0010;
  localparam logic [31:0] ST0  = 32'hC000_0000;
  localparam logic [31:0] PAT  = 32'h5A5A_0000;
  logic        clk, rst_n, start, can_commit, ld_ready;
  logic        ready, done, undef_trap, dop_go, ld_valid, st_next;
  chs_op_t     op_in;
  logic [2:0]  supported;
  logic [3:0]  word_count;
  logic [1:0]  resp_seen;
  logic [31:0] st_data, wb_base, ld_data;
  logic [31:0] aq[$], ldq[$], stq[$];
  int          n_mismatch = 0, compares = 0, cycles = 0, ndop = 0;
  chs_link_if link ();
  wire logic xfer = link.coproc_instr_n & link.opcode_fetch_n & ~link.mem_request_n;
  // released bus shows the inverse, never a stale word
  wire logic [31:0] bus = link.coproc_word_oe ? link.coproc_word : ~link.coproc_word;
  assign link.mem_rdata = (xfer && !link.write_not_read) ? link.addr ^ PAT : ~link.addr;
  chs_cpu_end i_chs_cpu_end (.clk(clk), .rst_n(rst_n), .link(link.cpu), .start(start),
    .op_in(op_in), .pc_in(PC), .base_in(BASE), .offset_in(OFF), .ready(ready),
    .done(done), .undef_trap(undef_trap), .wb_base(wb_base), .resp_seen(resp_seen));
  chs_cop_end i_chs_cop_end (.clk(clk), .rst_n(rst_n), .link(link.cop), .supported(supported),
    .can_commit(can_commit), .word_count(word_count), .dop_go(dop_go), .ld_valid(ld_valid),
    .ld_ready(ld_ready), .ld_data(ld_data), .st_data(st_data), .st_next(st_next));
  chs_link_monitor i_mon (.clk(clk), .rst_n(rst_n), .addr(link.addr),
    .mem_request_n(link.mem_request_n), .burst_follow(link.burst_follow),
    .opcode_fetch_n(link.opcode_fetch_n), .coproc_instr_n(link.coproc_instr_n),
    .write_not_read(link.write_not_read), .byte_not_word(link.byte_not_word), .op(link.op),
    .coproc_absent(link.coproc_absent), .coproc_busy(link.coproc_busy));
  ////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // capture of link traffic and user streams
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (ld_valid && ld_ready) ldq.push_back(ld_data);
    if (xfer) aq.push_back(link.addr);
    if (xfer && link.write_not_read) stq.push_back(bus);
    if (dop_go) ndop++;
    if (st_next) st_data <= st_data + 32'h1;
  end
  // hang guard, well above the run length
  always @(posedge clk)
    if (cycles == 2000)
    begin
      n_mismatch++;
      print_verdict();
    end
  task automatic print_verdict;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one operation; commit offered at cycle d, outcome judged at cycle nd
  task automatic run_op(input chs_op_t o, input logic [3:0] wc, input int d, input int nd,
                        input logic trap);
    int n;
    n = 0;
    aq.delete();
    stq.delete();
    ndop = 0;
    @(negedge clk);
    `CHK("ready idle", 1'b1, ready)
    op_in = o;
    word_count = wc;
    can_commit = (d == 1);
    st_data = ST0;
    start = 1'b1;
    repeat (nd)
    begin
      @(negedge clk);
      n++;
      start = 1'b0;
      if (n == d) can_commit = 1'b1;
      if (n == 1) `CHK("issue addr", PC + CHS_PC_REQ, link.addr)
      if (n < d) `CHK("busy wait", 2'b01, {link.coproc_absent, link.coproc_busy})
      if (n == 1) `CHK("ready busy", 1'b0, ready)
      if (n > 1 && n <= d) `CHK("resp wait", 2'b01, resp_seen)
      if (n == d + 1) `CHK("resp final", trap ? 2'b11 : 2'b00, resp_seen)
    end
    if (trap) `CHK("trap", 1'b1, undef_trap)
    else `CHK("done", 1'b1, done)
    if (!trap) `CHK("next addr", PC + CHS_PC_NEXT, link.addr)
  endtask
  task automatic chk_burst(input int w, input logic st);
    repeat (3) @(negedge clk);
    `CHK("words", w, aq.size())
    for (int k = 0; k < w; k++)
    begin
      `CHK("xfer addr", BASE + OFF + 4 * k, aq[k])
      if (st) `CHK("store word", ST0 + k, stq[k])
      else `CHK("load word", (BASE + OFF + 4 * k) ^ PAT, ldq[k])
    end
    `CHK("write back", BASE + OFF + 4 * w, wb_base)
  endtask
  ////////////////////////////////////////
  task automatic t_data;
    run_op(CHS_OP_DATA, 4'h1, 1, 2, 1'b0);
    `CHK("commit pulses", 1, ndop)
    run_op(CHS_OP_DATA, 4'h1, 4, 5, 1'b0);
    `CHK("commit pulses", 1, ndop)
  endtask
  task automatic t_load;
    ldq.delete();
    run_op(CHS_OP_LOAD, 4'h3, 1, 5, 1'b0);
    `CHK("no data commit", 0, ndop)
    chk_burst(3, 1'b0);
    ldq.delete();
    run_op(CHS_OP_LOAD, 4'h0, 3, 5, 1'b0);
    chk_burst(1, 1'b0);
  endtask
  task automatic t_store;
    run_op(CHS_OP_STORE, 4'h4, 2, 7, 1'b0);
    chk_burst(4, 1'b1);
  endtask
  // receiver stalls: burst ends at two words, none lost
  task automatic t_buffer;
    ldq.delete();
    ld_ready = 1'b0;
    run_op(CHS_OP_LOAD, 4'h4, 1, 4, 1'b0);
    repeat (2) @(negedge clk);
    `CHK("held words", 0, ldq.size())
    `CHK("held valid", 1'b1, ld_valid)
    ld_ready = 1'b1;
    chk_burst(2, 1'b0);
    `CHK("drained", 1'b0, ld_valid)
  endtask
  task automatic t_undef;
    supported = 3'b011;
    run_op(CHS_OP_STORE, 4'h1, 1, 2, 1'b1);
    `CHK("no transfer", 0, aq.size())
    supported = 3'b111;
  endtask
  initial
  begin
    rst_n = 1'b0;
    start = 1'b0;
    op_in = CHS_OP_DATA;
    supported = 3'b111;
    can_commit = 1'b1;
    word_count = 4'h1;
    ld_ready = 1'b1;
    st_data = ST0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_data();
    t_load();
    t_store();
    t_buffer();
    t_undef();
    print_verdict();
  end
endmodule
